//--- isrc_pkg.sv
// Constants and types of the standby release controller
package isrc_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] ADDR_STANDBY_CTRL = 4'h0;
    localparam logic [3:0] ADDR_EDGE_FIRST = 4'h1;
    localparam logic [3:0] ADDR_EDGE_SECOND = 4'h2;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
    localparam logic [3:0] ADDR_MACRO_SVC = 4'h4;
    localparam logic [3:0] ADDR_OSC_SETTLE = 4'h5;
    localparam logic [3:0] ADDR_ADC_MODE = 4'h6;
    localparam logic [3:0] ADDR_DAC_MODE = 4'h7;
    localparam logic [3:0] ADDR_PORT_LATCH = 4'h8;
    localparam logic [3:0] ADDR_PORT_MODE = 4'h9;
    localparam logic [3:0] ADDR_PORT_CTRL = 4'hA;
    localparam logic [3:0] ADDR_STATUS = 4'hB;
    // Field positions
    localparam int STBY_STOP_BIT = 0;
    localparam int STBY_IDLE_BIT = 1;
    localparam int EDGE_NMI_BIT = 0;
    localparam int EDGE_PIN_A_BIT = 0;
    localparam int EDGE_PIN_B_BIT = 1;
    localparam int MASK_PIN_A_BIT = 0;
    localparam int MASK_PIN_B_BIT = 1;
    localparam int EXT_CLK_SEL_BIT = 7;
    localparam int ADC_CONV_EN_BIT = 7;
    localparam int DAC_EN0_BIT = 0;
    localparam int DAC_EN1_BIT = 1;
    // Wake source indices
    localparam int SRC_NMI = 0;
    localparam int SRC_PIN_A = 1;
    localparam int SRC_PIN_B = 2;
    // Reset values
    localparam logic [7:0] RST_EDGE_FIRST = 8'h00;
    localparam logic [7:0] RST_EDGE_SECOND = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'hFF;
    localparam logic [7:0] RST_MACRO_SVC = 8'h00;
    localparam logic [7:0] RST_OSC_SETTLE = 8'h00;
    localparam logic [7:0] RST_ADC_MODE = 8'h00;
    localparam logic [7:0] RST_DAC_MODE = 8'h00;
    localparam logic [7:0] RST_PORT_LATCH = 8'h00;
    localparam logic [7:0] RST_PORT_MODE = 8'hFF;
    localparam logic [7:0] RST_PORT_CTRL = 8'h00;
    // Clocks after a refused standby entry before interrupts are acknowledged
    localparam logic [2:0] SLIP_CLOCKS = 3'h6;

    // Operating states
    typedef enum logic [1:0] {ST_RUN, ST_SLIP, ST_IDLE, ST_STOP} isrc_state_t;
endpackage

//--- isrc_edge_detect.sv
// Selectable edge detector for the three wake pins
`timescale 1ns/1ps
module isrc_edge_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and edge selection, 1 selects the rising edge
    input wire logic [2:0] pins,
    input wire logic [2:0] rise_sel,
    // One-cycle edge events
    output logic [2:0] evt
);
    logic [2:0] prev_r;

    // Previous level of each pin
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_r <= 3'h0;
        end
        else
        begin
            prev_r <= pins;
        end
    end

    // Edge match per pin
    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_pin
            assign evt[i] = rise_sel[i] ? (pins[i] & ~prev_r[i]) : (~pins[i] & prev_r[i]);
        end
    endgenerate
endmodule

//--- isrc_top.sv
// Standby entry, wake release and pin state controller
// Functional notes
// RULE_01: Only NMI, two pins or reset wake
// RULE_02: NMI edge from first select register wakes
// RULE_03: Acknowledgeable NMI wake branches to its routine
// RULE_04: Unacknowledgeable NMI resumes, stays pending for later
// RULE_05: Pin wakes only if unmasked, no macro service
// RULE_06: Pin wake branches only with enable and acknowledge
// RULE_07: Unserviced wake stays pending until acknowledgeable
// RULE_08: Standby refused while a release condition holds
// RULE_09: External clock select stops the oscillator
// RULE_10: External clock users set select before STOP
// RULE_11: Outside source drives inverted clock on second pin
// RULE_12: Buses and strobes float in STOP and IDLE
// RULE_13: Latch strobe floats, hold acknowledge held fixed
// RULE_14: Cleared conversion enable cuts reference current
// RULE_15: DAC runs; both enables clear floats outputs
// RULE_16: Control-mode pin follows peripheral hardware
// RULE_17: Port-mode pin follows latch and mode register
// RULE_18: Software places three no-ops after standby
// RULE_19: Interrupt held off six clocks after collision
`timescale 1ns/1ps
module isrc_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Wake pins
    input wire logic NMI_PIN,
    input wire logic EXT_IRQ_PIN_A,
    input wire logic EXT_IRQ_PIN_B,
    // CPU interrupt handshake
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic NMI_ACK_OK,
    input wire logic MASK_ACK_OK,
    input wire logic CPU_ACK,
    output logic VECTOR_REQ,
    output logic [1:0] VECTOR_SRC,
    output logic RESUME,
    output logic STANDBY_REFUSED,
    output logic CPU_CLK_EN,
    // External bus pin enables and fixed levels
    input wire logic HOLD_ACK_IN,
    output logic BUS_OE,
    output logic ADDRESS_LATCH_STROBE_OE,
    output logic HOLD_ACK_OUT,
    // Analog and oscillator controls
    output logic OSC_RUN,
    output logic ADC_REF_EN,
    output logic DAC_POWER,
    output logic [1:0] DAC_ANALOG_OE,
    // General port
    input wire logic [7:0] PERIPH_OUT,
    input wire logic [7:0] PERIPH_OE,
    output logic [7:0] PORT_OUT,
    output logic [7:0] PORT_OE
);
    typedef struct packed {
        isrc_pkg::isrc_state_t st;
        logic [2:0] pend;
        logic [2:0] slip_cnt;
        logic [7:0] edge1, edge2, mask, macro, osc, adc, dac, latch, pmode, cmode;
        logic [7:0] rdata;
        logic vreq;
        logic [1:0] vsrc;
        logic resume, refused, clk_en;
        logic bus_oe, address_latch_strobe_oe, hold_ack, osc_run, adc_ref, dac_pwr;
        logic [1:0] dac_oe;
        logic [7:0] port_out, port_oe;
    } isrc_regs_t;

    isrc_regs_t s_r;
    isrc_regs_t s_nxt;
    logic [2:0] evt;
    logic [2:0] elig;
    logic [7:0] port_out_nxt;
    logic [7:0] port_oe_nxt;

    // Edge detection with programmed polarity
    isrc_edge_detect u_edge (
        .clk(CLK),
        .rst(RST),
        .pins({EXT_IRQ_PIN_B, EXT_IRQ_PIN_A, NMI_PIN}),
        .rise_sel({s_r.edge2[isrc_pkg::EDGE_PIN_B_BIT], s_r.edge2[isrc_pkg::EDGE_PIN_A_BIT],
                   s_r.edge1[isrc_pkg::EDGE_NMI_BIT]}),
        .evt(evt)
    );

    // Wake-eligible events: NMI always, pins only unmasked without macro service
    assign elig[isrc_pkg::SRC_NMI] = evt[isrc_pkg::SRC_NMI]; // RULE_02
    assign elig[isrc_pkg::SRC_PIN_A] = evt[isrc_pkg::SRC_PIN_A]
        & ~s_r.mask[isrc_pkg::MASK_PIN_A_BIT] & ~s_r.macro[isrc_pkg::MASK_PIN_A_BIT]; // RULE_05
    assign elig[isrc_pkg::SRC_PIN_B] = evt[isrc_pkg::SRC_PIN_B]
        & ~s_r.mask[isrc_pkg::MASK_PIN_B_BIT] & ~s_r.macro[isrc_pkg::MASK_PIN_B_BIT]; // RULE_05

    // Per-pin output mux: control mode or port mode
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_port
            assign port_out_nxt[i] = s_r.cmode[i] ? PERIPH_OUT[i] : s_r.latch[i]; // RULE_16 RULE_17
            assign port_oe_nxt[i] = s_r.cmode[i] ? PERIPH_OE[i] : ~s_r.pmode[i]; // RULE_16 RULE_17
        end
    endgenerate

    // Next state of the whole block
    always_comb
    begin
        logic stby_wr;
        logic nmi_ok;
        logic pin_ok;
        logic [2:0] ackable;
        stby_wr = WR && (ADDR == isrc_pkg::ADDR_STANDBY_CTRL)
            && (WDATA[isrc_pkg::STBY_STOP_BIT] || WDATA[isrc_pkg::STBY_IDLE_BIT]);
        nmi_ok = NMI_ACK_OK;
        pin_ok = GLOBAL_IRQ_ENABLE && MASK_ACK_OK; // RULE_06
        ackable = {pin_ok, pin_ok, nmi_ok};
        s_nxt = s_r;
        s_nxt.resume = 1'b0;
        s_nxt.refused = 1'b0;
        // Register writes
        if (WR)
        begin
            case (ADDR)
                isrc_pkg::ADDR_EDGE_FIRST: s_nxt.edge1 = WDATA;
                isrc_pkg::ADDR_EDGE_SECOND: s_nxt.edge2 = WDATA;
                isrc_pkg::ADDR_IRQ_MASK: s_nxt.mask = WDATA;
                isrc_pkg::ADDR_MACRO_SVC: s_nxt.macro = WDATA;
                isrc_pkg::ADDR_OSC_SETTLE: s_nxt.osc = WDATA;
                isrc_pkg::ADDR_ADC_MODE: s_nxt.adc = WDATA;
                isrc_pkg::ADDR_DAC_MODE: s_nxt.dac = WDATA;
                isrc_pkg::ADDR_PORT_LATCH: s_nxt.latch = WDATA;
                isrc_pkg::ADDR_PORT_MODE: s_nxt.pmode = WDATA;
                isrc_pkg::ADDR_PORT_CTRL: s_nxt.cmode = WDATA;
                default: s_nxt.osc = s_nxt.osc;
            endcase
        end
        // Pending: acknowledge clears, a new event in the same cycle wins
        if (CPU_ACK && s_r.vreq)
        begin
            s_nxt.pend[s_r.vsrc] = 1'b0;
        end
        s_nxt.pend = s_nxt.pend | elig; // RULE_07
        // State sequencing
        case (s_r.st)
            isrc_pkg::ST_RUN:
            begin
                if (stby_wr && (|(s_r.pend | elig))) // RULE_08
                begin
                    s_nxt.refused = 1'b1;
                    s_nxt.st = isrc_pkg::ST_SLIP;
                    s_nxt.slip_cnt = isrc_pkg::SLIP_CLOCKS - 3'h1; // RULE_19
                end
                else if (stby_wr && WDATA[isrc_pkg::STBY_STOP_BIT])
                begin
                    s_nxt.st = isrc_pkg::ST_STOP;
                end
                else if (stby_wr)
                begin
                    s_nxt.st = isrc_pkg::ST_IDLE;
                end
            end
            isrc_pkg::ST_SLIP:
            begin
                if (s_r.slip_cnt == 3'h0)
                begin
                    s_nxt.st = isrc_pkg::ST_RUN;
                end
                else
                begin
                    s_nxt.slip_cnt = s_r.slip_cnt - 3'h1; // RULE_19
                end
            end
            isrc_pkg::ST_IDLE, isrc_pkg::ST_STOP:
            begin
                if (|elig) // RULE_01
                begin
                    s_nxt.st = isrc_pkg::ST_RUN;
                    s_nxt.resume = ~|(elig & ackable); // RULE_04 RULE_06
                end
            end
            default: s_nxt.st = isrc_pkg::ST_RUN;
        endcase
        // Vector request from pending sources, NMI first, only while running
        s_nxt.vreq = 1'b0;
        s_nxt.vsrc = 2'h0;
        if (s_nxt.st == isrc_pkg::ST_RUN)
        begin
            if (s_nxt.pend[isrc_pkg::SRC_NMI] && nmi_ok) // RULE_03 RULE_04
            begin
                s_nxt.vreq = 1'b1;
                s_nxt.vsrc = 2'(isrc_pkg::SRC_NMI);
            end
            else if (s_nxt.pend[isrc_pkg::SRC_PIN_A] && pin_ok) // RULE_06
            begin
                s_nxt.vreq = 1'b1;
                s_nxt.vsrc = 2'(isrc_pkg::SRC_PIN_A);
            end
            else if (s_nxt.pend[isrc_pkg::SRC_PIN_B] && pin_ok) // RULE_06
            begin
                s_nxt.vreq = 1'b1;
                s_nxt.vsrc = 2'(isrc_pkg::SRC_PIN_B);
            end
        end
        // CPU clock and bus pins follow the next operating state, the other outputs their registers
        s_nxt.clk_en = (s_nxt.st == isrc_pkg::ST_RUN) || (s_nxt.st == isrc_pkg::ST_SLIP);
        s_nxt.bus_oe = s_nxt.clk_en; // RULE_12
        s_nxt.address_latch_strobe_oe = s_nxt.clk_en; // RULE_13
        s_nxt.hold_ack = s_nxt.clk_en ? HOLD_ACK_IN : 1'b0; // RULE_13
        s_nxt.osc_run = ~s_nxt.osc[isrc_pkg::EXT_CLK_SEL_BIT]; // RULE_09
        s_nxt.adc_ref = s_nxt.adc[isrc_pkg::ADC_CONV_EN_BIT]; // RULE_14
        s_nxt.dac_oe = {s_nxt.dac[isrc_pkg::DAC_EN1_BIT], s_nxt.dac[isrc_pkg::DAC_EN0_BIT]};
        s_nxt.dac_pwr = |s_nxt.dac_oe; // RULE_15
        s_nxt.port_out = port_out_nxt;
        s_nxt.port_oe = port_oe_nxt;
        // Read data, one cycle after the strobe
        s_nxt.rdata = 8'h00;
        if (RD)
        begin
            case (ADDR)
                isrc_pkg::ADDR_STANDBY_CTRL: s_nxt.rdata = {6'h00, s_r.st};
                isrc_pkg::ADDR_EDGE_FIRST: s_nxt.rdata = s_r.edge1;
                isrc_pkg::ADDR_EDGE_SECOND: s_nxt.rdata = s_r.edge2;
                isrc_pkg::ADDR_IRQ_MASK: s_nxt.rdata = s_r.mask;
                isrc_pkg::ADDR_MACRO_SVC: s_nxt.rdata = s_r.macro;
                isrc_pkg::ADDR_OSC_SETTLE: s_nxt.rdata = s_r.osc;
                isrc_pkg::ADDR_ADC_MODE: s_nxt.rdata = s_r.adc;
                isrc_pkg::ADDR_DAC_MODE: s_nxt.rdata = s_r.dac;
                isrc_pkg::ADDR_PORT_LATCH: s_nxt.rdata = s_r.latch;
                isrc_pkg::ADDR_PORT_MODE: s_nxt.rdata = s_r.pmode;
                isrc_pkg::ADDR_PORT_CTRL: s_nxt.rdata = s_r.cmode;
                isrc_pkg::ADDR_STATUS: s_nxt.rdata = {s_r.slip_cnt, s_r.pend, s_r.st};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
    end

    // State register; reset is a wake source of its own
    always_ff @(posedge CLK)
    begin
        if (RST) // RULE_01
        begin
            s_r <= '0;
            s_r.st <= isrc_pkg::ST_RUN;
            s_r.clk_en <= 1'b1;
            s_r.osc_run <= 1'b1;
            s_r.edge1 <= isrc_pkg::RST_EDGE_FIRST;
            s_r.edge2 <= isrc_pkg::RST_EDGE_SECOND;
            s_r.mask <= isrc_pkg::RST_IRQ_MASK;
            s_r.macro <= isrc_pkg::RST_MACRO_SVC;
            s_r.osc <= isrc_pkg::RST_OSC_SETTLE;
            s_r.adc <= isrc_pkg::RST_ADC_MODE;
            s_r.dac <= isrc_pkg::RST_DAC_MODE;
            s_r.latch <= isrc_pkg::RST_PORT_LATCH;
            s_r.pmode <= isrc_pkg::RST_PORT_MODE;
            s_r.cmode <= isrc_pkg::RST_PORT_CTRL;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign RDATA = s_r.rdata;
    assign VECTOR_REQ = s_r.vreq;
    assign VECTOR_SRC = s_r.vsrc;
    assign RESUME = s_r.resume;
    assign STANDBY_REFUSED = s_r.refused;
    assign CPU_CLK_EN = s_r.clk_en;
    assign BUS_OE = s_r.bus_oe;
    assign ADDRESS_LATCH_STROBE_OE = s_r.address_latch_strobe_oe;
    assign HOLD_ACK_OUT = s_r.hold_ack;
    assign OSC_RUN = s_r.osc_run;
    assign ADC_REF_EN = s_r.adc_ref;
    assign DAC_POWER = s_r.dac_pwr;
    assign DAC_ANALOG_OE = s_r.dac_oe;
    assign PORT_OUT = s_r.port_out;
    assign PORT_OE = s_r.port_oe;

    // Checks on the release and pin behaviour
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    sequence s_in_idle;
        s_r.st == isrc_pkg::ST_IDLE;
    endsequence
    sequence s_nmi_wake;
        s_in_idle ##0 elig[isrc_pkg::SRC_NMI];
    endsequence
    sequence s_refused_entry;
        s_r.st == isrc_pkg::ST_RUN && WR && ADDR == isrc_pkg::ADDR_STANDBY_CTRL
            && WDATA[isrc_pkg::STBY_IDLE_BIT] && (|s_r.pend);
    endsequence

    a_nmi_wake_run: assert property (s_nmi_wake |=> s_r.st == isrc_pkg::ST_RUN && s_r.clk_en) // RULE_02
        else $error("NMI edge did not release idle");
    a_nmi_wake_branch: assert property (s_nmi_wake ##0 NMI_ACK_OK |=> s_r.vreq && !s_r.resume) // RULE_03
        else $error("Acknowledgeable NMI wake did not request its vector");
    a_nmi_wake_resume: assert property (s_nmi_wake ##0 !NMI_ACK_OK && !(|elig[2:1]) // RULE_04
        |=> s_r.resume && s_r.pend[isrc_pkg::SRC_NMI])
        else $error("Unacknowledgeable NMI wake did not resume with pending");
    a_masked_no_wake: assert property (s_in_idle ##0 !(|elig) |=> s_r.st == isrc_pkg::ST_IDLE) // RULE_05
        else $error("Idle left without an eligible wake");
    a_pin_no_ie: assert property (!GLOBAL_IRQ_ENABLE && !(|s_nxt.pend[0]) |=> !s_r.vreq) // RULE_06
        else $error("Pin vector requested with interrupts disabled");
    a_pend_hold: assert property (s_r.pend[isrc_pkg::SRC_PIN_A] && !(CPU_ACK && s_r.vreq) // RULE_07
        |=> s_r.pend[isrc_pkg::SRC_PIN_A])
        else $error("Pending wake dropped without acknowledge");
    a_refuse_entry: assert property (s_refused_entry |=> s_r.refused ##0 s_r.st == isrc_pkg::ST_SLIP) // RULE_08
        else $error("Standby entered while a release condition held");
    a_slip_six: assert property (s_refused_entry |=> (!s_r.vreq)[*6] ##1 s_r.st == isrc_pkg::ST_RUN) // RULE_19
        else $error("Slip window not six clocks");
    a_bus_float: assert property (s_r.st inside {isrc_pkg::ST_IDLE, isrc_pkg::ST_STOP} // RULE_12 RULE_13
        |-> !s_r.bus_oe && !s_r.address_latch_strobe_oe && !s_r.hold_ack)
        else $error("Bus driven during standby");
    a_osc_stop: assert property (s_r.osc[isrc_pkg::EXT_CLK_SEL_BIT] |-> !s_r.osc_run) // RULE_09
        else $error("Oscillator running with external clock selected");
    a_dac_float: assert property (s_r.dac[1:0] == 2'h0 |-> !s_r.dac_pwr && s_r.dac_oe == 2'h0) // RULE_15
        else $error("Converter outputs not floated with both enables clear");
    a_port_ctrl: assert property (s_r.cmode[0] |=> s_r.port_out[0] == $past(PERIPH_OUT[0])) // RULE_16
        else $error("Control-mode pin not following peripheral");
endmodule

//--- isrc_cpu_partner.sv
// Model of the wake pin sources and the CPU interrupt acknowledge side
`timescale 1ns/1ps
module isrc_cpu_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench commands
    input wire logic [2:0] pin_cmd,
    input wire logic ie_cmd,
    input wire logic nmi_ok_cmd,
    input wire logic mask_ok_cmd,
    input wire logic [7:0] ack_dly,
    // Pins and CPU levels toward the block
    output logic nmi_pin,
    output logic pin_a,
    output logic pin_b,
    output logic ie,
    output logic nmi_ok,
    output logic mask_ok,
    // Acknowledge handshake
    input wire logic vector_req,
    input wire logic [1:0] vector_src,
    output logic cpu_ack,
    // Record of vectors taken
    output logic [7:0] ack_cnt,
    output logic [1:0] last_src
);
    logic [7:0] wait_r;

    // Pin levels and CPU state come straight from the bench commands
    assign nmi_pin = pin_cmd[0];
    assign pin_a = pin_cmd[1];
    assign pin_b = pin_cmd[2];
    assign ie = ie_cmd;
    assign nmi_ok = nmi_ok_cmd;
    assign mask_ok = mask_ok_cmd;

    // Takes a vector after a set delay, only while it is requested
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cpu_ack <= 1'b0;
            wait_r <= 8'h00;
            ack_cnt <= 8'h00;
            last_src <= 2'h0;
        end
        else if (cpu_ack)
        begin
            cpu_ack <= 1'b0;
            wait_r <= 8'h00;
        end
        else if (vector_req)
        begin
            if (wait_r == ack_dly)
            begin
                cpu_ack <= 1'b1;
                ack_cnt <= ack_cnt + 8'h01;
                last_src <= vector_src;
            end
            else
                wait_r <= wait_r + 8'h01;
        end
        else
            wait_r <= 8'h00;
    end
endmodule

//--- tb.sv
// Self-checking bench of the standby release controller
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [3:0] addr; logic [7:0] wdata; logic [4:0] outs;} isrc_row_t;
    logic CLK, RST, WR, RD, HOLD_ACK_IN, ie, nmi_ok, mask_ok, cpu_ack, nmi_p, pa, pb, gie, nok, mok;
    logic [3:0] ADDR;
    logic [7:0] WDATA, RDATA, PORT_OUT, PORT_OE, rd, acks, ack_dly, n0, periph;
    logic [2:0] pins;
    logic [1:0] VECTOR_SRC, DAC_ANALOG_OE, last_src;
    logic VECTOR_REQ, RESUME, STANDBY_REFUSED, CPU_CLK_EN, BUS_OE, ADDRESS_LATCH_STROBE_OE;
    logic HOLD_ACK_OUT, OSC_RUN, ADC_REF_EN, DAC_POWER;
    int num_errors = 0, tests_run = 0, resumes = 0, n, r0;
    logic [7:0] rstv [1:12] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hFF, 8'h00, 8'h00, 8'h00};
    // Output bits: osc run, adc ref, dac power, dac output enables
    isrc_row_t rows [0:7] = '{'{isrc_pkg::ADDR_OSC_SETTLE, 8'h80, 5'h00},
        '{isrc_pkg::ADDR_OSC_SETTLE, 8'h00, 5'h10}, '{isrc_pkg::ADDR_ADC_MODE, 8'h80, 5'h18},
        '{isrc_pkg::ADDR_ADC_MODE, 8'h00, 5'h10}, '{isrc_pkg::ADDR_DAC_MODE, 8'h01, 5'h15},
        '{isrc_pkg::ADDR_DAC_MODE, 8'h02, 5'h16}, '{isrc_pkg::ADDR_DAC_MODE, 8'h03, 5'h17},
        '{isrc_pkg::ADDR_DAC_MODE, 8'h00, 5'h10}};

    isrc_top i_dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .NMI_PIN(nmi_p), .EXT_IRQ_PIN_A(pa), .EXT_IRQ_PIN_B(pb),
        .GLOBAL_IRQ_ENABLE(gie), .NMI_ACK_OK(nok), .MASK_ACK_OK(mok), .CPU_ACK(cpu_ack),
        .VECTOR_REQ(VECTOR_REQ), .VECTOR_SRC(VECTOR_SRC), .RESUME(RESUME),
        .STANDBY_REFUSED(STANDBY_REFUSED), .CPU_CLK_EN(CPU_CLK_EN),
        .HOLD_ACK_IN(HOLD_ACK_IN), .BUS_OE(BUS_OE),
        .ADDRESS_LATCH_STROBE_OE(ADDRESS_LATCH_STROBE_OE), .HOLD_ACK_OUT(HOLD_ACK_OUT),
        .OSC_RUN(OSC_RUN), .ADC_REF_EN(ADC_REF_EN), .DAC_POWER(DAC_POWER),
        .DAC_ANALOG_OE(DAC_ANALOG_OE), .PERIPH_OUT(periph), .PERIPH_OE(8'hC3),
        .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE));
    isrc_cpu_partner i_cpu (.clk(CLK), .rst(RST), .pin_cmd(pins), .ie_cmd(ie),
        .nmi_ok_cmd(nmi_ok), .mask_ok_cmd(mask_ok), .ack_dly(ack_dly), .nmi_pin(nmi_p),
        .pin_a(pa), .pin_b(pb), .ie(gie), .nmi_ok(nok), .mask_ok(mok),
        .vector_req(VECTOR_REQ), .vector_src(VECTOR_SRC), .cpu_ack(cpu_ack),
        .ack_cnt(acks), .last_src(last_src));

    // Clock and resume pulse counter
    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    always @(posedge CLK) if (RESUME === 1'b1) resumes <= resumes + 1;

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin num_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end
    endtask
    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin num_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK); ADDR <= a; WDATA <= d; WR <= 1'b1;
        @(posedge CLK); WR <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a, output logic [7:0] d);
        @(posedge CLK); ADDR <= a; RD <= 1'b1;
        @(posedge CLK); RD <= 1'b0; #1; d = RDATA;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask
    // Enter standby and check the floated bus pins
    task automatic sleep(input logic [7:0] m);
        wr(isrc_pkg::ADDR_STANDBY_CTRL, m);
        cyc(3);
        chk1(CPU_CLK_EN, 1'b0);
        chk1(BUS_OE, 1'b0);
        chk1(ADDRESS_LATCH_STROBE_OE, 1'b0);
        chk1(HOLD_ACK_OUT, 1'b0);
    endtask
    // Bounded wait for the clock to run again
    task automatic wait_run;
        int k;
        k = 0;
        while (CPU_CLK_EN !== 1'b1 && k < 40) begin cyc(1); k++; end
        chk1(CPU_CLK_EN, 1'b1);
        chk1(BUS_OE, 1'b1);
    endtask
    // Bounded wait for one more vector taken by the partner
    task automatic wait_ack(input logic [7:0] c, input logic [1:0] src);
        int k;
        k = 0;
        while (acks === c && k < 80) begin cyc(1); k++; end
        chk8(acks, c + 8'h01);
        chk8({6'h00, last_src}, {6'h00, src});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #400000;
        num_errors++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        tally_and_finish;
    end

    // Main sequence
    initial
    begin
        RST = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = 4'h0; WDATA = 8'h00; HOLD_ACK_IN = 1'b1;
        pins = 3'h0; ie = 1'b1; nmi_ok = 1'b1; mask_ok = 1'b1; ack_dly = 8'h00;
        periph = 8'h3C;
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        cyc(2);
        chk8({OSC_RUN, CPU_CLK_EN, BUS_OE, HOLD_ACK_OUT, 4'h0}, 8'hF0);
        wr(isrc_pkg::ADDR_STATUS, 8'hFF);
        wr(4'hC, 8'hFF);
        for (int a = 1; a <= 12; a++) begin rdr(a[3:0], rd); chk8(rd, rstv[a]); end
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            wr(rows[i].addr, rows[i].wdata);
            rdr(rows[i].addr, rd);
            chk8(rd, rows[i].wdata);
            cyc(2);
            chk8({3'h0, OSC_RUN, ADC_REF_EN, DAC_POWER, DAC_ANALOG_OE}, {3'h0, rows[i].outs});
        end
        $display("test table done");
        wr(isrc_pkg::ADDR_PORT_LATCH, 8'hA5);
        wr(isrc_pkg::ADDR_PORT_MODE, 8'h0F);
        wr(isrc_pkg::ADDR_PORT_CTRL, 8'hF0);
        cyc(3);
        chk8(PORT_OUT, 8'h35);
        chk8(PORT_OE, 8'hC0);
        periph <= 8'hC3;
        cyc(3);
        chk8(PORT_OUT, 8'hC5);
        $display("test port done");
        // Masked pin A edge, then an acknowledgeable NMI wake
        wr(isrc_pkg::ADDR_EDGE_FIRST, 8'h01);
        wr(isrc_pkg::ADDR_EDGE_SECOND, 8'h01);
        n0 = acks;
        sleep(8'h02);
        pins[1] <= 1'b1;
        cyc(10);
        chk1(CPU_CLK_EN, 1'b0);
        pins[0] <= 1'b1;
        wait_run;
        wait_ack(n0, 2'h0);
        cyc(5);
        chk8(acks, n0 + 8'h01);
        $display("test nmi wake done");
        // NMI wake that cannot be taken resumes, then stays pending
        pins <= 3'h0;
        nmi_ok <= 1'b0;
        r0 = resumes;
        n0 = acks;
        sleep(8'h02);
        pins[0] <= 1'b1;
        wait_run;
        cyc(2);
        chk8(8'(resumes), 8'(r0 + 1));
        chk1(VECTOR_REQ, 1'b0);
        nmi_ok <= 1'b1;
        wait_ack(n0, 2'h0);
        $display("test nmi pending done");
        // STOP with external clock selected, released by NMI
        pins[0] <= 1'b0;
        wr(isrc_pkg::ADDR_OSC_SETTLE, 8'h80);
        n0 = acks;
        sleep(8'h01);
        chk1(OSC_RUN, 1'b0);
        pins[0] <= 1'b1;
        wait_run;
        wait_ack(n0, 2'h0);
        wr(isrc_pkg::ADDR_OSC_SETTLE, 8'h00);
        $display("test stop done");
        // Pin A under macro service ignored, pin B falling edge wakes
        pins <= 3'h4;
        wr(isrc_pkg::ADDR_IRQ_MASK, 8'h00);
        wr(isrc_pkg::ADDR_MACRO_SVC, 8'h01);
        n0 = acks;
        sleep(8'h02);
        pins[1] <= 1'b1;
        cyc(10);
        chk1(CPU_CLK_EN, 1'b0);
        pins[2] <= 1'b0;
        wait_run;
        wait_ack(n0, 2'h2);
        // Pin A wake with global enable clear resumes, then pends
        wr(isrc_pkg::ADDR_MACRO_SVC, 8'h00);
        pins[1] <= 1'b0;
        ie <= 1'b0;
        mask_ok <= 1'b0;
        r0 = resumes;
        n0 = acks;
        sleep(8'h02);
        pins[1] <= 1'b1;
        wait_run;
        cyc(2);
        chk8(8'(resumes), 8'(r0 + 1));
        chk1(VECTOR_REQ, 1'b0);
        ie <= 1'b1;
        cyc(2);
        chk1(VECTOR_REQ, 1'b0);
        mask_ok <= 1'b1;
        wait_ack(n0, 2'h1);
        $display("test pin wake done");
        // Standby write while a request is pending is refused
        ack_dly <= 8'd30;
        pins[0] <= 1'b0;
        cyc(2);
        pins[0] <= 1'b1;
        cyc(4);
        chk1(VECTOR_REQ, 1'b1);
        n0 = acks;
        wr(isrc_pkg::ADDR_STANDBY_CTRL, 8'h02);
        #1;
        chk1(STANDBY_REFUSED, 1'b1);
        chk1(CPU_CLK_EN, 1'b1);
        n = 0;
        while (VECTOR_REQ !== 1'b1 && n < 20) begin n++; cyc(1); end
        chk1(n >= 6 && n <= 8, 1'b1);
        ack_dly <= 8'h00;
        wait_ack(n0, 2'h0);
        $display("test refuse done");
        // Reset in mid-run releases idle
        sleep(8'h02);
        RST <= 1'b1;
        cyc(2);
        RST <= 1'b0;
        cyc(2);
        chk1(CPU_CLK_EN, 1'b1);
        chk1(BUS_OE, 1'b1);
        $display("test reset wake done");
        tally_and_finish;
    end
endmodule
